// ===== src/iepr_pkg.sv
// Constants for the interrupt enable and priority register bank.
// Assumes an 8-bit special-function register bus with page select.
package iepr_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_BASE_PRIO = 8'hB8;
	localparam logic [7:0] ADDR_EXT_EN_ONE = 8'hE6;
	localparam logic [7:0] ADDR_EXT_EN_TWO = 8'hE7;
	localparam logic [7:0] ADDR_EXT_PRIO_ONE = 8'hF6;
	// Pages that reach the first extended priority register
	localparam logic [7:0] PAGE_LOW = 8'h00;
	localparam logic [7:0] PAGE_CFG = 8'h0F;
	// Reset values
	localparam logic [7:0] RST_BASE_PRIO = 8'h80;
	localparam logic [7:0] RST_EXT_EN_ONE = 8'h00;
	localparam logic [7:0] RST_EXT_EN_TWO = 8'h00;
	localparam logic [7:0] RST_EXT_PRIO_ONE = 8'h00;
	// Writable bits of the base priority and second extended enable registers
	localparam logic [7:0] WMASK_BASE_PRIO = 8'h7F;
	localparam logic [7:0] WMASK_EXT_EN_TWO = 8'h05;
	// Bit positions in the second extended enable register
	localparam int POS_REG_DROPOUT = 0;
	localparam int POS_PORT_MATCH = 2;
	// Source counts
	localparam int N_BASE = 7;
	localparam int N_EXT = 8;
	localparam int N_SRC = 17;
	// Service levels
	typedef enum logic [1:0] {
		IEPR_IDLE,
		IEPR_LOW,
		IEPR_HIGH
	} iepr_level_t;
endpackage : iepr_pkg

// ===== src/iepr_regs.sv
// Interrupt mask and priority register bank with a two-level preemption
// tracker. Assumes the core drives a one-cycle write or bit-write strobe,
// reads combinationally, and pulses ack on vectoring and reti on return.
// Contract
// - Base priority top bit reads one always
// - Base priority bits six-zero set source priority
// - Base priority at B8, all pages, bitwise
// - Enable one bit7 gates LIN request
// - Enable one bit6 gates timer three
// - Enable one bits5,4 gate comparators
// - Enable one bits2,1 gate converter flags
// - Enable one bits3,0 gate counter, two-wire
// - Enable one at E6, all pages
// - Priority one bits match enable one
// - Priority one at F6, pages 00/0F
// - Enable two unused bits read zero
// - Enable two bit2 gates port match
// - Enable two bit0 gates regulator dropout
// - Enable two at E7, all pages
// - Global enable blocks every source
`timescale 1ns/10ps
module iepr_regs (
	input wire logic ref_clk,
	input wire logic rst,
	// Core register access
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Global enable from the base enable register
	input wire logic global_irq_enable,
	// Base sources already masked by their base enable bits
	input wire logic [6:0] base_req,
	// Extended source flags
	input wire logic lin_pending_flag,
	input wire logic timer_three_low_overflow,
	input wire logic timer_three_high_overflow,
	input wire logic comparator_b_rise_flag,
	input wire logic comparator_b_fall_flag,
	input wire logic comparator_a_rise_flag,
	input wire logic comparator_a_fall_flag,
	input wire logic counter_array_req,
	input wire logic conv_done_flag,
	input wire logic conv_window_flag,
	input wire logic two_wire_req,
	input wire logic port_match_req,
	input wire logic regulator_dropout_req,
	// Priority of the two sources beyond this bank
	input wire logic port_match_prio,
	input wire logic regulator_dropout_prio,
	// Core handshake
	input wire logic irq_ack,
	input wire logic irq_reti,
	output logic irq_req,
	output logic irq_req_high,
	output logic [16:0] irq_gated,
	output logic [1:0] irq_level
);

	// Stored registers
	logic [7:0] base_priority_select_reg;
	logic [7:0] base_priority_select_next;
	logic [7:0] ext_enable_one_reg;
	logic [7:0] ext_enable_one_next;
	logic [7:0] ext_enable_two_reg;
	logic [7:0] ext_enable_two_next;
	logic [7:0] ext_priority_one_reg;
	logic [7:0] ext_priority_one_next;
	// Service state: stack of active levels
	logic low_active_reg;
	logic low_active_next;
	logic high_active_reg;
	logic high_active_next;
	// Combined request and priority vectors
	logic [16:0] raw_req;
	logic [16:0] prio_vec;
	logic [16:0] gated;
	logic any_high;
	logic any_low;

	// Merge a whole-byte or single-bit write into a register
	// Byte write wins over a bit write in the same cycle
	// Bit writes reach every register; the core only issues them
	// to bit-addressable locations
	function automatic logic [7:0] merge_write(
		input logic [7:0] cur,
		input logic [7:0] wmask,
		input logic wr,
		input logic bwr,
		input logic [2:0] bsel,
		input logic bval,
		input logic [7:0] wdata
	);
		logic [7:0] nv;
		nv = cur;
		if (wr) begin
			nv = wdata;
		end else if (bwr) begin
			nv[bsel] = bval;
		end
		merge_write = (nv & wmask) | (cur & ~wmask);
	endfunction : merge_write

	// Address decode, also used for read mux
	// decode of base priority, both enable and priority one registers
	function automatic logic [1:0] decode_sel(
		input logic [7:0] addr,
		input logic [7:0] page,
		output logic hit
	);
		hit = 1'b1;
		decode_sel = 2'd0;
		if (addr == iepr_pkg::ADDR_BASE_PRIO) begin
			decode_sel = 2'd0;
		end else if (addr == iepr_pkg::ADDR_EXT_EN_ONE) begin
			decode_sel = 2'd1;
		end else if (addr == iepr_pkg::ADDR_EXT_EN_TWO) begin
			decode_sel = 2'd2;
		end else if (addr == iepr_pkg::ADDR_EXT_PRIO_ONE &&
				(page == iepr_pkg::PAGE_LOW ||
				page == iepr_pkg::PAGE_CFG)) begin
			decode_sel = 2'd3;
		end else begin
			hit = 1'b0;
		end
	endfunction : decode_sel

	logic [1:0] sel;
	logic hit;
	logic any_wr;

	// Decode once per cycle
	always_comb begin
		sel = decode_sel(sfr_addr, sfr_page, hit);
		any_wr = hit & (sfr_wr | sfr_bit_wr);
	end

	// Register next values
	always_comb begin
		base_priority_select_next = base_priority_select_reg;
		ext_enable_one_next = ext_enable_one_reg;
		ext_enable_two_next = ext_enable_two_reg;
		ext_priority_one_next = ext_priority_one_reg;
		if (any_wr) begin
			unique case (sel)
				2'd0: begin
					base_priority_select_next = merge_write(
						base_priority_select_reg,
						iepr_pkg::WMASK_BASE_PRIO, sfr_wr, sfr_bit_wr,
						sfr_bit_sel, sfr_bit_val, sfr_wdata);
				end
				2'd1: begin
					ext_enable_one_next = merge_write(ext_enable_one_reg,
						8'hFF, sfr_wr, sfr_bit_wr, sfr_bit_sel,
						sfr_bit_val, sfr_wdata);
				end
				2'd2: begin
					ext_enable_two_next = merge_write(ext_enable_two_reg,
						iepr_pkg::WMASK_EXT_EN_TWO, sfr_wr, sfr_bit_wr,
						sfr_bit_sel, sfr_bit_val, sfr_wdata);
				end
				2'd3: begin
					ext_priority_one_next = merge_write(
						ext_priority_one_reg, 8'hFF, sfr_wr, sfr_bit_wr,
						sfr_bit_sel, sfr_bit_val, sfr_wdata);
				end
			endcase
		end
	end

	// Register storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			base_priority_select_reg <= iepr_pkg::RST_BASE_PRIO;
			ext_enable_one_reg <= iepr_pkg::RST_EXT_EN_ONE;
			ext_enable_two_reg <= iepr_pkg::RST_EXT_EN_TWO;
			ext_priority_one_reg <= iepr_pkg::RST_EXT_PRIO_ONE;
		end else begin
			base_priority_select_reg <= base_priority_select_next;
			ext_enable_one_reg <= ext_enable_one_next;
			ext_enable_two_reg <= ext_enable_two_next;
			ext_priority_one_reg <= ext_priority_one_next;
		end
	end

	// Read mux; unmapped reads give zero
	always_comb begin
		sfr_hit = hit;
		sfr_rdata = 8'h00;
		if (hit) begin
			unique case (sel)
				2'd0: sfr_rdata = base_priority_select_reg | 8'h80;
				2'd1: sfr_rdata = ext_enable_one_reg;
				2'd2: sfr_rdata = ext_enable_two_reg &
					iepr_pkg::WMASK_EXT_EN_TWO;
				2'd3: sfr_rdata = ext_priority_one_reg;
			endcase
		end
	end

	// Source gating; bit order is the extended enable layout
	always_comb begin
		raw_req = 17'h00000;
		raw_req[6:0] = base_req;
		raw_req[7] = two_wire_req & ext_enable_one_reg[0];
		raw_req[8] = conv_window_flag & ext_enable_one_reg[1];
		raw_req[9] = conv_done_flag & ext_enable_one_reg[2];
		raw_req[10] = counter_array_req & ext_enable_one_reg[3];
		raw_req[11] = (comparator_a_rise_flag | comparator_a_fall_flag) &
			ext_enable_one_reg[4];
		raw_req[12] = (comparator_b_rise_flag | comparator_b_fall_flag) &
			ext_enable_one_reg[5];
		raw_req[13] = (timer_three_low_overflow |
			timer_three_high_overflow) & ext_enable_one_reg[6];
		raw_req[14] = lin_pending_flag & ext_enable_one_reg[7];
		raw_req[15] = regulator_dropout_req &
			ext_enable_two_reg[iepr_pkg::POS_REG_DROPOUT];
		raw_req[16] = port_match_req &
			ext_enable_two_reg[iepr_pkg::POS_PORT_MATCH];
		// Top two priority bits come from outside this bank
		// base priorities in bits six-zero, priority one above them
		prio_vec = {port_match_prio, regulator_dropout_prio,
			ext_priority_one_reg, base_priority_select_reg[6:0]};
		gated = raw_req & {17{global_irq_enable}};
		any_high = |(gated & prio_vec);
		any_low = |(gated & ~prio_vec);
	end

	// Service level next state
	always_comb begin
		low_active_next = low_active_reg;
		high_active_next = high_active_reg;
		// Return and vectoring in one cycle: return wins, so the
		// level stack never grows and shrinks at once
		if (irq_reti) begin
			// Return unwinds the innermost level
			if (high_active_reg) begin
				high_active_next = 1'b0;
			end else begin
				low_active_next = 1'b0;
			end
		end else if (irq_ack) begin
			// Vectoring takes the level of the winning request
			if (irq_req_high) begin
				high_active_next = 1'b1;
			end else if (irq_req) begin
				low_active_next = 1'b1;
			end
		end
	end

	// Service level storage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_active_reg <= 1'b0;
			high_active_reg <= 1'b0;
		end else begin
			low_active_reg <= low_active_next;
			high_active_reg <= high_active_next;
		end
	end

	// Request to the core; equal level never preempts
	// Combinational so a fresh request is seen in its own cycle
	always_comb begin
		irq_req_high = any_high & ~high_active_reg;
		irq_req = irq_req_high |
			(any_low & ~low_active_reg & ~high_active_reg);
		irq_gated = gated;
		if (high_active_reg) begin
			irq_level = iepr_pkg::IEPR_HIGH;
		end else if (low_active_reg) begin
			irq_level = iepr_pkg::IEPR_LOW;
		end else begin
			irq_level = iepr_pkg::IEPR_IDLE;
		end
	end

endmodule : iepr_regs

// ===== testbench/iepr_core_model.sv
// Core stand-in: vectors and returns on bench command.
// Pulses launched at the falling edge, one cycle wide.
`timescale 1ns/10ps
module iepr_core_model (
	input wire logic ref_clk,
	input wire logic irq_req,
	input wire logic take,
	input wire logic ret,
	output logic irq_ack,
	output logic irq_reti
);
	initial {irq_ack, irq_reti} = 2'h0;
	// Never two acks in a row, so one request is taken once
	always @(negedge ref_clk) begin
		irq_ack <= take & irq_req & ~irq_ack;
		irq_reti <= ret & ~irq_reti;
	end
endmodule : iepr_core_model

// ===== testbench/iepr_regs_props.sv
// Port-level checks on the register bank.
// Bound from the bench top; single clock domain.
`timescale 1ns/10ps
module iepr_regs_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic global_irq_enable,
	input wire logic lin_pending_flag,
	input wire logic irq_ack,
	input wire logic irq_reti,
	input wire logic irq_req,
	input wire logic irq_req_high,
	input wire logic [16:0] irq_gated,
	input wire logic [1:0] irq_level
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	top_bit_a: assert property (sfr_hit && sfr_addr == 8'hB8
		|-> sfr_rdata[7]) else $error("base top bit low");
	two_unused_a: assert property (sfr_hit && sfr_addr == 8'hE7
		|-> (sfr_rdata & 8'hFA) == 8'h00) else $error("unused bits set");
	prio_page_a: assert property (sfr_addr == 8'hF6
		|-> sfr_hit == (sfr_page == 8'h00 || sfr_page == 8'h0F))
		else $error("priority page decode");
	all_pages_a: assert property (sfr_addr inside {8'hB8, 8'hE6, 8'hE7}
		|-> sfr_hit) else $error("page-free decode");
	global_off_a: assert property (!global_irq_enable
		|-> irq_gated == 17'h00000 && !irq_req) else $error("global leak");
	lin_gate_a: assert property (sfr_wr && sfr_addr == 8'hE6 |=>
		irq_gated[14] == ($past(sfr_wdata[7]) && lin_pending_flag
		&& global_irq_enable)) else $error("lin gate");
	take_high_a: assert property (irq_ack && !irq_reti && irq_req_high
		|=> irq_level == 2'h2) else $error("high not entered");
	take_low_a: assert property (irq_ack && !irq_reti && irq_req
		&& !irq_req_high && irq_level == 2'h0 |=> irq_level == 2'h1)
		else $error("low not entered");
	low_block_a: assert property (irq_level == 2'h1
		|-> irq_req == irq_req_high) else $error("low level preempted");
	no_equal_a: assert property (irq_level == 2'h2 |-> !irq_req)
		else $error("equal preempt");
	cover property (irq_level == 2'h2);
	cover property (sfr_addr == 8'hF6 && !sfr_hit);
	cover property (irq_ack && !irq_req_high);
	cover property (irq_level == 2'h2 && irq_reti);
endmodule : iepr_regs_props

// ===== testbench/tb.sv
// Bench for the enable and priority register bank.
// Needs the checker and core stand-in compiled first.
`timescale 1ns/10ps
module tb;
	logic ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
	logic [7:0] sfr_page = 8'h05, sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic sfr_bit_val = 1'b0, global_irq_enable = 1'b0, flg = 1'b0;
	logic pm = 1'b0, take = 1'b0, ret = 1'b0; // Levels and core commands
	logic [6:0] base_req = 7'h00;
	logic irq_ack, irq_reti, irq_req, irq_req_high, sfr_hit;
	logic [7:0] sfr_rdata;
	logic [16:0] irq_gated;
	logic [1:0] irq_level;
	int err_total = 0, n_checks = 0;
	always #5 ref_clk = ~ref_clk;
	// One flag drives every extended source; mask bits separate them
	iepr_regs DUT (.ref_clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata,
		.sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .sfr_hit,
		.global_irq_enable, .base_req, .lin_pending_flag(flg),
		.timer_three_low_overflow(flg), .timer_three_high_overflow(flg),
		.comparator_b_rise_flag(flg), .comparator_b_fall_flag(flg),
		.comparator_a_rise_flag(flg), .comparator_a_fall_flag(flg),
		.counter_array_req(flg), .conv_done_flag(flg),
		.conv_window_flag(flg), .two_wire_req(flg), .port_match_req(flg),
		.regulator_dropout_req(flg), .port_match_prio(pm),
		.regulator_dropout_prio(pm), .irq_ack, .irq_reti, .irq_req,
		.irq_req_high, .irq_gated, .irq_level);
	iepr_core_model core (.ref_clk, .irq_req, .take, .ret, .irq_ack,
		.irq_reti);
	task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// Strobe held across exactly one rising edge
	task automatic wr(logic [7:0] a, logic [7:0] d, logic bit_mode = 1'b0);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = d;
		{sfr_bit_val, sfr_bit_sel} = d[3:0];
		sfr_wr = !bit_mode;
		sfr_bit_wr = bit_mode;
		@(negedge ref_clk);
		{sfr_wr, sfr_bit_wr} = 2'h0;
	endtask : wr
	// Hit and data compared together
	task automatic rd(logic [7:0] a, logic [8:0] e);
		@(negedge ref_clk);
		sfr_addr = a;
		#1 chk("read", {8'h00, e}, {8'h00, sfr_hit, sfr_rdata});
	endtask : rd
	// Core takes whatever is offered, off the edge to avoid races
	task automatic serve(logic [1:0] lvl);
		#1 take = 1'b1;
		repeat (3) @(negedge ref_clk);
		#1 take = 1'b0;
		chk("level", {15'h0000, lvl}, {15'h0000, irq_level});
	endtask : serve
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		rd(8'hB8, 9'h180);
		rd(8'hE6, 9'h100);
		rd(8'hE7, 9'h100);
		rd(8'hF6, 9'h000);
		rd(8'h55, 9'h000);
		wr(8'hB8, 8'hFF);
		wr(8'hE6, 8'hFF);
		wr(8'hE7, 8'hFF);
		wr(8'hF6, 8'hFF);
		rd(8'hB8, 9'h1FF);
		rd(8'hE6, 9'h1FF);
		rd(8'hE7, 9'h105);
		sfr_page = 8'h0F;
		rd(8'hF6, 9'h100);
		wr(8'hF6, 8'hA5);
		sfr_page = 8'h00;
		rd(8'hF6, 9'h1A5);
		wr(8'hB8, 8'h07, 1'b1);
		wr(8'hB8, 8'h03, 1'b1);
		rd(8'hB8, 9'h1F7);
		wr(8'hB8, 8'h0B, 1'b1);
		rd(8'hB8, 9'h1FF);
		global_irq_enable = 1'b1;
		flg = 1'b1;
		// Walk one mask bit at a time
		for (int i = 0; i < 8; i++) begin
			wr(8'hE6, 8'h01 << i);
			#1 chk("gate", {2'h3, 8'h01 << i, 7'h00}, irq_gated);
			chk("prio", {9'h000, 8'hA5 >> i} & 17'h00001,
				{16'h0000, irq_req_high});
		end
		wr(8'hE7, 8'h01);
		#1 chk("dropout", {2'h1, 8'h80, 7'h00}, irq_gated);
		wr(8'hE7, 8'h04);
		#1 chk("match", {2'h2, 8'h80, 7'h00}, irq_gated);
		global_irq_enable = 1'b0;
		#1 chk("global", 17'h00000, irq_gated);
		flg = 1'b0;
		wr(8'hB8, 8'h00);
		global_irq_enable = 1'b1;
		base_req = 7'h01;
		serve(2'h1);
		chk("equal", 17'h00000, {16'h0000, irq_req});
		wr(8'hB8, 8'h02);
		base_req = 7'h03;
		#1 chk("high", 17'h00001, {16'h0000, irq_req_high});
		serve(2'h2);
		ret = 1'b1;
		@(negedge ref_clk);
		#1 ret = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("unwind", 17'h00001, {15'h0000, irq_level});
		final_report;
	end
	// Tests need about 70 cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_total++;
		final_report;
	end
endmodule : tb
bind iepr_regs iepr_regs_props chk_i (.ref_clk(ref_clk), .rst(rst),
	.sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.global_irq_enable(global_irq_enable),
	.lin_pending_flag(lin_pending_flag), .irq_ack(irq_ack),
	.irq_reti(irq_reti), .irq_req(irq_req), .irq_req_high(irq_req_high),
	.irq_gated(irq_gated), .irq_level(irq_level));
